// *** core/dcc_regs.sv ***
// Control and data registers of two 12-bit converters, with input latches.
// Assumes the core drives whole-byte SPECIAL_FUNCTION_REGISTER accesses synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module dcc_regs
	import dcc_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Special function register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_sel,
	// Converter controls
	output var dcc_chan_t    conv0_q,
	output var dcc_chan_t    conv1_q
);
	// Shared control register
	logic [7:0]        ctl_q;
	logic [7:0]        ctl_d;

	// Data byte registers
	logic [7:0]        c0l_q;
	logic [7:0]        c0l_d;
	logic [7:0]        c0h_q;
	logic [7:0]        c0h_d;
	logic [7:0]        c1l_q;
	logic [7:0]        c1l_d;
	logic [7:0]        c1h_q;
	logic [7:0]        c1h_d;

	// Read path
	logic [7:0]        rdata_d;
	logic              sel_d;

	// Address decode and write enables
	logic              hit_ctl;
	logic              hit_c0l;
	logic              hit_c0h;
	logic              hit_c1l;
	logic              hit_c1h;
	logic              wr_ctl;
	logic              wr_c0l;
	logic              wr_c0h;
	logic              wr_c1l;
	logic              wr_c1h;

	// Converter input latches
	logic              sync_rise;
	logic              load0;
	logic              load1;
	logic [CODE_W-1:0] code0;
	logic [CODE_W-1:0] code1;
	logic [CODE_W-1:0] lat0_q;
	logic [CODE_W-1:0] lat0_d;
	logic [CODE_W-1:0] lat1_q;
	logic [CODE_W-1:0] lat1_d;

	// Converter-facing outputs
	dcc_chan_t         conv0_d;
	dcc_chan_t         conv1_d;

	always_comb begin
		hit_ctl = 1'b0;
		hit_c0l = 1'b0;
		hit_c0h = 1'b0;
		hit_c1l = 1'b0;
		hit_c1h = 1'b0;
		if (sfr_addr == ADDR_CONTROL) begin
			hit_ctl = 1'b1;
		end else if (sfr_addr == ADDR_CONV0_LOW) begin
			hit_c0l = 1'b1;
		end else if (sfr_addr == ADDR_CONV0_HIGH) begin
			hit_c0h = 1'b1;
		end else if (sfr_addr == ADDR_CONV1_LOW) begin
			hit_c1l = 1'b1;
		end else if (sfr_addr == ADDR_CONV1_HIGH) begin
			hit_c1h = 1'b1;
		end
		// No bit strobe exists, so every write replaces the whole byte
		wr_ctl = sfr_wr & hit_ctl;
		wr_c0l = sfr_wr & hit_c0l;
		wr_c0h = sfr_wr & hit_c0h;
		wr_c1l = sfr_wr & hit_c1l;
		wr_c1h = sfr_wr & hit_c1h;
	end

	// Control register next value
	always_comb begin
		ctl_d = ctl_q;
		if (wr_ctl) begin
			ctl_d = sfr_wdata;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_q <= CONTROL_RESET;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	// Data byte next values; upper nibbles are stored so they read back
	always_comb begin
		c0l_d = c0l_q;
		c0h_d = c0h_q;
		c1l_d = c1l_q;
		c1h_d = c1h_q;
		if (wr_c0l) begin
			c0l_d = sfr_wdata;
		end
		if (wr_c0h) begin
			c0h_d = sfr_wdata;
		end
		if (wr_c1l) begin
			c1l_d = sfr_wdata;
		end
		if (wr_c1h) begin
			c1h_d = sfr_wdata;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			c0l_q <= DATA_RESET;
			c0h_q <= DATA_RESET;
			c1l_q <= DATA_RESET;
			c1h_q <= DATA_RESET;
		end else begin
			c0l_q <= c0l_d;
			c0h_q <= c0h_d;
			c1l_q <= c1l_d;
			c1h_q <= c1h_d;
		end
	end

	always_comb begin
		sel_d   = hit_ctl | hit_c0l | hit_c0h | hit_c1l | hit_c1h;
		rdata_d = READ_IDLE;
		if (sfr_rd) begin
			if (hit_ctl) begin
				rdata_d = ctl_q;
			end else if (hit_c0l) begin
				rdata_d = c0l_q;
			end else if (hit_c0h) begin
				rdata_d = c0h_q;
			end else if (hit_c1l) begin
				rdata_d = c1l_q;
			end else if (hit_c1h) begin
				rdata_d = c1h_q;
			end
		end
	end

	// Idle reads return zero so a stale byte never lingers on the bus
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sfr_rdata <= READ_IDLE;
			sfr_sel   <= 1'b0;
		end else begin
			sfr_rdata <= rdata_d;
			sfr_sel   <= sel_d;
		end
	end

	// Codes are formed from the values after this cycle's write, so a low byte
	// write and its latch land on the same edge
	always_comb begin
		if (ctl_d[BIT_MODE8]) begin
			code0 = {NIB_ZERO, c0l_d};
			code1 = {NIB_ZERO, c1l_d};
		end else begin
			code0 = {c0h_d[CODE_W-LOW_W-1:0], c0l_d};
			code1 = {c1h_d[CODE_W-LOW_W-1:0], c1l_d};
		end
	end

	// Latch load events
	always_comb begin
		sync_rise = ctl_d[BIT_SYNC] & ~ctl_q[BIT_SYNC];
		load0 = sync_rise | (ctl_q[BIT_SYNC] & wr_c0l);
		load1 = sync_rise | (ctl_q[BIT_SYNC] & wr_c1l);
		lat0_d = lat0_q;
		lat1_d = lat1_q;
		if (load0) begin
			lat0_d = code0;
		end
		if (load1) begin
			lat1_d = code1;
		end
	end

	// The latch keeps its code while clear is active, so releasing clear
	// brings back the last loaded value without a new write
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lat0_q <= CODE_ZERO;
			lat1_q <= CODE_ZERO;
		end else begin
			lat0_q <= lat0_d;
			lat1_q <= lat1_d;
		end
	end

	// Converter-facing controls follow the control byte after this cycle's write
	always_comb begin
		conv0_d.code = ctl_d[BIT_CONV0_ZERO_FORCE_N_N] ? lat0_d : CODE_ZERO;
		conv1_d.code = ctl_d[BIT_CONV1_ZERO_FORCE_N_N] ? lat1_d : CODE_ZERO;
		conv0_d.range_supply = ctl_d[BIT_RANGE0];
		conv1_d.range_supply = ctl_d[BIT_RANGE1];
		conv0_d.power_on = ctl_d[BIT_PWR0];
		conv1_d.power_on = ctl_d[BIT_PWR1];
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			conv0_q <= '0;
			conv1_q <= '0;
		end else begin
			conv0_q <= conv0_d;
			conv1_q <= conv1_d;
		end
	end
endmodule
`default_nettype wire

// *** core/dcc_pkg.sv ***
// Package for the dual converter control registers.
// Assumes an 8-bit special function register bus on the core clock.
package dcc_pkg;
	localparam logic [7:0] ADDR_CONV0_LOW  = 8'hf9;
	localparam logic [7:0] ADDR_CONV0_HIGH = 8'hfa;
	localparam logic [7:0] ADDR_CONV1_LOW  = 8'hfb;
	localparam logic [7:0] ADDR_CONV1_HIGH = 8'hfc;
	localparam logic [7:0] ADDR_CONTROL    = 8'hfd;
	localparam logic [7:0] DATA_RESET      = 8'h00;
	localparam logic [7:0] CONTROL_RESET   = 8'h00;
	localparam int BIT_MODE8  = 7;
	localparam int BIT_RANGE1 = 6;
	localparam int BIT_RANGE0 = 5;
	localparam int BIT_CONV1_ZERO_FORCE_N_N = 4;
	localparam int BIT_CONV0_ZERO_FORCE_N_N = 3;
	localparam int BIT_SYNC   = 2;
	localparam int BIT_PWR1   = 1;
	localparam int BIT_PWR0   = 0;
	localparam int CODE_W     = 12;
	localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
	localparam int LOW_W = 8;
	localparam logic [CODE_W-LOW_W-1:0] NIB_ZERO = '0;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Converter-facing controls for one channel
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic              range_supply;
		logic              power_on;
	} dcc_chan_t;
endpackage

// *** sim/dcc_monitor.sv ***
// Checker for dcc_regs.
// Bound in; sees the ports only.
`timescale 1ns/1ps
`default_nettype none
module dcc_monitor
	import dcc_pkg::*;
(
	// Clock and reset
	input wire logic       mclk,
	input wire logic       sys_rst,
	// Register port
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_sel,
	// Converter controls
	input wire dcc_chan_t  conv0_q,
	input wire dcc_chan_t  conv1_q
);
	wire logic wc = sfr_wr && sfr_addr == ADDR_CONTROL;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	rd_idle_a: assert property (!sfr_rd |=> !sfr_rdata) else $error("rdata");
	rd_miss_a: assert property (sfr_rd && sfr_addr == 8'hf8 |=> !sfr_rdata) else $error("miss");
	sel_ctl_a: assert property (sfr_addr == ADDR_CONTROL |=> sfr_sel) else $error("sel");
	// Converter outputs may only move after a write
	hold_ch0_a: assert property (!sfr_wr |=> $stable(conv0_q)) else $error("ch0");
	hold_ch1_a: assert property (!sfr_wr |=> $stable(conv1_q)) else $error("ch1");
	clr_ch0_a: assert property (wc && !sfr_wdata[BIT_CONV0_ZERO_FORCE_N_N] |=> !conv0_q.code) else $error("conv0_zero_force_n");
	clr_ch1_a: assert property (wc && !sfr_wdata[BIT_CONV1_ZERO_FORCE_N_N] |=> !conv1_q.code) else $error("conv1_zero_force_n");
	pwr_ch0_a: assert property (wc |=> conv0_q.power_on == $past(sfr_wdata[BIT_PWR0])) else $error("pwr0");
	pwr_ch1_a: assert property (wc |=> conv1_q.power_on == $past(sfr_wdata[BIT_PWR1])) else $error("pwr1");
	rng_ch1_a: assert property (wc |=> conv1_q.range_supply == $past(sfr_wdata[BIT_RANGE1])) else $error("conv1_range_select");
endmodule
bind dcc_regs dcc_monitor dcc_monitor_inst (
	.mclk      (mclk),
	.sys_rst   (sys_rst),
	.sfr_wr    (sfr_wr),
	.sfr_rd    (sfr_rd),
	.sfr_addr  (sfr_addr),
	.sfr_wdata (sfr_wdata),
	.sfr_rdata (sfr_rdata),
	.sfr_sel   (sfr_sel),
	.conv0_q   (conv0_q),
	.conv1_q   (conv1_q)
);
`default_nettype wire

// *** sim/dcc_regs_test.sv ***
// Random bench for dcc_regs.
// Drives the SPECIAL_FUNCTION_REGISTER port itself.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_control_regs_test import dcc_pkg::*; ;
	logic        mclk        = 1'b0;
	logic        sys_rst     = 1'b1;
	logic        sfr_wr      = 1'b0;
	logic        sfr_rd      = 1'b0;
	logic        sfr_sel;
	logic [7:0]  sfr_addr    = 8'h00;
	logic [7:0]  sfr_wdata   = 8'h00;
	logic [7:0]  sfr_rdata;
	logic [7:0]  r [8]       = '{default: 8'h00};
	logic [11:0] m0          = 12'h000;
	logic [11:0] m1          = 12'h000;
	dcc_chan_t   conv0_q;
	dcc_chan_t   conv1_q;
	int          fails       = 0;
	int          check_count = 0;
	dcc_regs dcc_regs_inst (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.sfr_addr  (sfr_addr),
		.sfr_wr    (sfr_wr),
		.sfr_rd    (sfr_rd),
		.sfr_wdata (sfr_wdata),
		.sfr_rdata (sfr_rdata),
		.sfr_sel   (sfr_sel),
		.conv0_q   (conv0_q),
		.conv1_q   (conv1_q)
	);
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic cmp_conv(input logic [27:0] g, input logic [27:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t converter controls %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_read(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t read data %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_sel(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t select %b expected %b", $time, g, e);
		end
	endtask
	task automatic stop_test;
		$display("%0d mismatches in %0d checks", fails, check_count);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Write one byte, then read one back on the next edge
	task automatic step(input logic [7:0] a, input logic [7:0] d, input logic [7:0] b);
		logic        s;
		logic [11:0] e0;
		logic [11:0] e1;
		s = r[5][BIT_SYNC];
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge mclk);
		#1;
		sfr_wr = 1'b0;
		sfr_addr = b;
		sfr_rd = 1'b1;
		r[a[2:0]] = d;
		if (r[5][BIT_SYNC] && (a == ADDR_CONV0_LOW || (a == ADDR_CONTROL && !s))) begin
			m0 = r[5][BIT_MODE8] ? {4'h0, r[1]} : {r[2][3:0], r[1]};
		end
		if (r[5][BIT_SYNC] && (a == ADDR_CONV1_LOW || (a == ADDR_CONTROL && !s))) begin
			m1 = r[5][BIT_MODE8] ? {4'h0, r[3]} : {r[4][3:0], r[3]};
		end
		e0 = r[5][BIT_CONV0_ZERO_FORCE_N_N] ? m0 : 12'h000;
		e1 = r[5][BIT_CONV1_ZERO_FORCE_N_N] ? m1 : 12'h000;
		@(posedge mclk);
		#1;
		sfr_rd = 1'b0;
		cmp_conv({conv0_q, conv1_q}, {e0, r[5][5], r[5][0], e1, r[5][6], r[5][1]});
		cmp_read(sfr_rdata, (b[2:0] % 6 != 0) ? r[b[2:0]] : 8'h00);
		cmp_sel(sfr_sel, b[2:0] % 6 != 0);
	endtask
	initial begin
		void'($urandom(32'h624eedb8));
		repeat (2) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		cmp_conv({conv0_q, conv1_q}, 28'h0000000);
		step(ADDR_CONV0_LOW, 8'h00, ADDR_CONV1_HIGH);
		step(ADDR_CONTROL, 8'h1f, ADDR_CONTROL);
		step(ADDR_CONV0_HIGH, 8'h0a, ADDR_CONV0_HIGH);
		step(ADDR_CONV0_LOW, 8'h5c, ADDR_CONV0_LOW);
		step(ADDR_CONTROL, 8'h1b, ADDR_CONTROL);
		step(ADDR_CONV1_LOW, 8'h33, ADDR_CONV1_LOW);
		step(ADDR_CONTROL, 8'h1f, ADDR_CONTROL);
		step(ADDR_CONTROL, 8'h0f, ADDR_CONTROL);
		step(ADDR_CONTROL, 8'h1f, ADDR_CONTROL);
		repeat (400) step(8'($urandom_range(254, 248)), 8'($urandom), 8'($urandom_range(254, 248)));
		sys_rst = 1'b1;
		@(posedge mclk);
		#1;
		sys_rst = 1'b0;
		r = '{default: 8'h00};
		m0 = 12'h000;
		m1 = 12'h000;
		cmp_conv({conv0_q, conv1_q}, 28'h0000000);
		step(ADDR_CONV1_HIGH, 8'h00, ADDR_CONV0_LOW);
		repeat (20) step(8'($urandom_range(254, 248)), 8'($urandom), 8'($urandom_range(254, 248)));
		stop_test;
	end
	// About 860 cycles of tests; 2000 cycles, over twice that, is a hang
	initial begin
		#50000;
		fails++;
		stop_test;
	end
endmodule
`default_nettype wire
